// *** logic/tmap_consts.svh ***
// Purpose: shared constants of the TUG-2 tributary mapper source
// Assumes: one path clock cycle carries one payload byte of the path frame
// Notes: times are kept in their own unit with derived cycle counts
`ifndef TMAP_CONSTS_SVH
`define TMAP_CONSTS_SVH

// tributary rates in 64/4 kbit/s units, nominal kbit/s
`define TMAP_TU2_RATE_UNITS 428
`define TMAP_TU12_RATE_UNITS 140
`define TMAP_TU12_RATE_KBPS 2240
`define TMAP_RATE_PPM 4.6

// path payload geometry: 20 groups of 12 columns, 9 rows, 4 frames
`define TMAP_COLS 8'hF0
`define TMAP_ROWS 4'h9
`define TMAP_GROUPS 8'h14
`define TMAP_MEMBERS 8'h03
`define TMAP_V3P1_STEP_TU2 8'h14
`define TMAP_V3P1_STEP_TU12 8'h3C
`define TMAP_TU2_BYTES 12'h1B0
`define TMAP_TU12_BYTES 12'h090
`define TMAP_MFRAME_US 500

// pointer bytes
`define TMAP_NDF_NORMAL 4'h6
`define TMAP_SS_TU2 2'h0
`define TMAP_SS_TU12 2'h2
`define TMAP_I_MASK 10'h2AA
`define TMAP_D_MASK 10'h155
`define TMAP_V4_FILL 8'h00
`define TMAP_AIS_BYTE 8'hFF
`define TMAP_IDLE_BYTE 8'h00

// elastic store
`define TMAP_BUF_AW 4
`define TMAP_FILL_HI 5'h0C
`define TMAP_FILL_LO 5'h04

// signal fail response: 1 ms at 50 ns per cycle
`define TMAP_SF_RESP_MS 1
`define TMAP_CLK_NS 50
`define TMAP_SF_RESP_CYC ((`TMAP_SF_RESP_MS * 1000000) / `TMAP_CLK_NS)

`endif

// *** logic/tmap_pkg.sv ***
// Purpose: types of the TUG-2 tributary mapper source
// Assumes: nothing beyond the constants header
// Notes: justification action taken once per multiframe
package tmap_pkg;
    typedef enum logic [1:0] {
        TMAP_JUST_NONE,
        TMAP_JUST_POS,
        TMAP_JUST_NEG
    } tmap_just_t;
endpackage

// *** logic/tmap_tug2_mapper.sv ***
// Purpose: map a VC-2 or VC-12 tributary into its TU timeslot of the path payload
// Assumes: clk_in is the path timing clock, one payload byte per cycle
// Notes: elastic store crosses from the tributary clock by gray pointers
// Function
// - accept large tributary stream, 428 x 64/4 kbit/s, +-4.6 ppm, with frame phase
// - accept small tributary stream, 2240 kbit/s, carried in a TU-12
// - elastic buffer written with data and frame start on tributary clock
// - buffer read on path clock and frame position, gated by justification
// - positive justification skips one byte read, V3+1 carries no data
// - negative justification reads one extra byte into V3
// - large frame phase coded in TU-2 pointer, justification as pointer moves
// - small frame phase coded in TU-12 pointer
// - pointer in V1 and V2 once per multiframe at fixed positions
// - TU-2 pointer carries size bits 00
// - TU-12 pointer carries size bits 10
// - TU-2 fills exactly 432 bytes per multiframe
// - TU-12 fills exactly 144 bytes per multiframe
// - TU-2 timeslot chosen by group index 1 to 20
// - TU-12 timeslot chosen by group 1 to 20 and member 1 to 3
// - only one instance may write a timeslot, others refused
// - drive the timeslot only while activated
// - signal fail gives all ones within 1 ms, normal data within 1 ms
// - unconnected signal fail input counts as false
// - V4 content is undefined
`timescale 1ns/1ps
`include "tmap_consts.svh"
module tmap_tug2_mapper #(
    parameter int SF_RESP_CYC = `TMAP_SF_RESP_CYC
) (
    // path clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // tributary side, on its own clock
    input wire logic trib_clk_in,
    input wire logic [7:0] vc_large_tributary_data_in,
    input wire logic [7:0] vc_small_tributary_data_in,
    input wire logic trib_byte_valid_in,
    input wire logic trib_frame_start_in,
    // path timing, same clock
    input wire logic path_frame_start_in,
    input wire logic path_multiframe_start_in,
    input wire logic timeslot_taken_in,
    // management and consequent action pins
    input wire logic function_activate_in,
    input wire logic upstream_signal_fail_in = 1'b0,
    input wire logic tu_is_small_in,
    input wire logic [4:0] group_l_in,
    input wire logic [1:0] member_m_in,
    // group access point
    output logic [7:0] group_access_data_out,
    output logic group_access_drive_out,
    output logic group_access_frame_start_out,
    output logic group_access_multiframe_start_out,
    output logic timeslot_claim_out
);
    import tmap_pkg::*;

    localparam int AW = `TMAP_BUF_AW;
    localparam int DEPTH = 1 << AW;

    // ****************************************
    // resets and pin synchronisers
    // ****************************************
    logic rst_meta_q, rst_n;
    logic trst_meta_q, trst_n;
    logic [9:0] pin_meta_q, pin_sync_q;
    logic act_s, sf_s, small_s;
    logic [4:0] l_s;
    logic [1:0] m_s;

    // path reset release
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // tributary reset release
    always_ff @(posedge trib_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            trst_meta_q <= 1'b0;
            trst_n <= 1'b0;
        end else begin
            trst_meta_q <= 1'b1;
            trst_n <= trst_meta_q;
        end
    end

    // pins from outside pass two flops
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_q <= 10'h000;
            pin_sync_q <= 10'h000;
        end else begin
            pin_meta_q <= {function_activate_in, upstream_signal_fail_in,
                tu_is_small_in, group_l_in, member_m_in};
            pin_sync_q <= pin_meta_q;
        end
    end
    assign {act_s, sf_s, small_s, l_s, m_s} = pin_sync_q;

    // ****************************************
    // elastic store, tributary side
    // ****************************************
    logic [7:0] mem_data [0:DEPTH-1];
    logic mem_fs [0:DEPTH-1];
    logic [AW:0] wr_bin_q, wr_gray_q, rgray_meta_q, rgray_sync_q, wr_bin_inc, rd_gray_q;
    logic wr_full, wr_en, tsmall_meta_q, tsmall_q;
    logic [7:0] trib_byte;

    function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
        logic [AW:0] b;
        b = g;
        for (int i = AW - 1; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    // one tributary port per tributary size
    assign trib_byte = tsmall_q ? vc_small_tributary_data_in
                                      : vc_large_tributary_data_in;
    assign wr_bin_inc = wr_bin_q + 1'b1;
    assign wr_full = (wr_gray_q == {~rgray_sync_q[AW:AW-1], rgray_sync_q[AW-2:0]});
    assign wr_en = trib_byte_valid_in && !wr_full;

    // write pointer, gray copy crosses to the path side
    always_ff @(posedge trib_clk_in or negedge trst_n) begin
        if (!trst_n) begin
            wr_bin_q <= '0;
            wr_gray_q <= '0;
        end else if (wr_en) begin
            wr_bin_q <= wr_bin_inc;
            wr_gray_q <= wr_bin_inc ^ (wr_bin_inc >> 1);
        end
    end

    // storage of data and frame start flag
    always_ff @(posedge trib_clk_in) begin
        if (wr_en) begin
            mem_data[wr_bin_q[AW-1:0]] <= trib_byte;
            mem_fs[wr_bin_q[AW-1:0]] <= trib_frame_start_in;
        end
    end

    // read pointer and size pin seen from the tributary side
    always_ff @(posedge trib_clk_in or negedge trst_n) begin
        if (!trst_n) begin
            rgray_meta_q <= '0;
            rgray_sync_q <= '0;
            tsmall_meta_q <= 1'b0;
            tsmall_q <= 1'b0;
        end else begin
            rgray_meta_q <= rd_gray_q;
            rgray_sync_q <= rgray_meta_q;
            tsmall_meta_q <= tu_is_small_in; // pin, two flops before the data mux
            tsmall_q <= tsmall_meta_q;
        end
    end

    // ****************************************
    // frame position on the path clock
    // ****************************************
    logic [7:0] col_q, cur_col, first_col, v3p1_col;
    logic [3:0] row_q, cur_row;
    logic [1:0] frm_q, cur_frm;
    logic own, vslot, v3p1;

    function automatic logic slot_owned(input logic [7:0] col, input logic is_small,
                                        input logic [4:0] l, input logic [1:0] m);
        logic grp_hit, mem_hit;
        grp_hit = (col % `TMAP_GROUPS) == (8'(l) - 8'h01);
        mem_hit = ((col / `TMAP_GROUPS) % `TMAP_MEMBERS) == (8'(m) - 8'h01);
        return grp_hit && (!is_small || mem_hit);
    endfunction

    assign cur_col = path_frame_start_in ? 8'h00 : col_q;
    assign cur_row = path_frame_start_in ? 4'h0 : row_q;
    assign cur_frm = path_multiframe_start_in ? 2'h0 :
                     (path_frame_start_in ? frm_q + 2'h1 : frm_q);
    assign own = slot_owned(cur_col, small_s, l_s, m_s);
    assign first_col = 8'(l_s) - 8'h01 +
                       (small_s ? 8'(`TMAP_GROUPS * (8'(m_s) - 8'h01)) : 8'h00);
    assign v3p1_col = first_col + (small_s ? `TMAP_V3P1_STEP_TU12 : `TMAP_V3P1_STEP_TU2);
    assign vslot = own && (cur_row == 4'h0) && (cur_col == first_col);
    assign v3p1 = own && (cur_row == 4'h0) && (cur_col == v3p1_col) && (cur_frm == 2'h2);

    // column, row and frame counters
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            col_q <= 8'h00;
            row_q <= 4'h0;
            frm_q <= 2'h0;
        end else begin
            frm_q <= cur_frm;
            if (cur_col == `TMAP_COLS - 8'h01) begin
                col_q <= 8'h00;
                row_q <= (cur_row == `TMAP_ROWS - 4'h1) ? 4'h0 : cur_row + 4'h1;
            end else begin
                col_q <= cur_col + 8'h01;
                row_q <= cur_row;
            end
        end
    end

    // ****************************************
    // elastic store, path side
    // ****************************************
    logic [AW:0] rd_bin_q, wgray_meta_q, wgray_sync_q, rd_bin_inc, fill;
    logic rd_en, empty;

    assign fill = gray2bin(wgray_sync_q) - rd_bin_q;
    assign empty = (fill == '0);
    assign rd_bin_inc = rd_bin_q + 1'b1;

    // write pointer seen from the path side
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            wgray_meta_q <= '0;
            wgray_sync_q <= '0;
        end else begin
            wgray_meta_q <= wr_gray_q;
            wgray_sync_q <= wgray_meta_q;
        end
    end

    // read pointer advances only on read enables, whether or not the slot is granted
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            rd_bin_q <= '0;
            rd_gray_q <= '0;
        end else if (rd_en) begin
            rd_bin_q <= rd_bin_inc;
            rd_gray_q <= rd_bin_inc ^ (rd_bin_inc >> 1);
        end
    end

    // ****************************************
    // justification and pointer
    // ****************************************
    tmap_just_t just_q;
    logic [9:0] ptr_q, cap_q, off_q, ptr_tx;
    logic [1:0] ss;

    assign ss = small_s ? `TMAP_SS_TU12 : `TMAP_SS_TU2;
    assign ptr_tx = ptr_q ^ ((just_q == TMAP_JUST_POS) ? `TMAP_I_MASK :
                             (just_q == TMAP_JUST_NEG) ? `TMAP_D_MASK : 10'h000);

    // decision from fill level at V4, acted on through the next multiframe
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            just_q <= TMAP_JUST_NONE;
        end else if (vslot && cur_frm == 2'h3) begin
            if (fill >= `TMAP_FILL_HI) begin
                just_q <= TMAP_JUST_NEG;
            end else if (fill <= `TMAP_FILL_LO) begin
                just_q <= TMAP_JUST_POS;
            end else begin
                just_q <= TMAP_JUST_NONE;
            end
        end
    end

    // payload offset counts from the byte after V2; frame start offset is the pointer
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            off_q <= 10'h000;
            cap_q <= 10'h000;
            ptr_q <= 10'h000;
        end else begin
            if (vslot && cur_frm == 2'h1) begin
                off_q <= 10'h000;
            end else if (rd_en) begin
                off_q <= off_q + 10'h001;
            end
            if (rd_en && mem_fs[rd_bin_q[AW-1:0]]) begin
                cap_q <= off_q;
            end
            if (vslot && cur_frm == 2'h3) begin
                ptr_q <= cap_q;
            end
        end
    end

    // ****************************************
    // byte selection for the timeslot
    // ****************************************
    logic [7:0] byte_d, rdata;

    assign rdata = mem_data[rd_bin_q[AW-1:0]];

    // picks pointer, justification or payload byte for this position
    always_comb begin
        rd_en = 1'b0;
        byte_d = `TMAP_IDLE_BYTE;
        if (vslot) begin
            case (cur_frm)
                2'h0: byte_d = {`TMAP_NDF_NORMAL, ss, ptr_tx[9:8]};
                2'h1: byte_d = ptr_tx[7:0];
                2'h2: begin
                    if (just_q == TMAP_JUST_NEG && !empty) begin
                        rd_en = 1'b1;
                        byte_d = rdata;
                    end
                end
                default: byte_d = `TMAP_V4_FILL;
            endcase
        end else if (own) begin
            if (v3p1 && just_q == TMAP_JUST_POS) begin
                byte_d = `TMAP_IDLE_BYTE;
            end else if (!empty) begin
                rd_en = 1'b1;
                byte_d = rdata;
            end
        end
    end

    // ****************************************
    // access point outputs and trail stage
    // ****************************************
    logic grant;
    assign grant = act_s && !timeslot_taken_in;

    // registered drive onto the group access point
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            group_access_data_out <= 8'h00;
            group_access_drive_out <= 1'b0;
            timeslot_claim_out <= 1'b0;
        end else begin
            timeslot_claim_out <= grant;
            group_access_drive_out <= grant && own;
            if (grant && own) begin
                group_access_data_out <= sf_s ? `TMAP_AIS_BYTE : byte_d;
            end else begin
                group_access_data_out <= 8'h00;
            end
        end
    end

    // trail stage: frame marks pass unchanged, aligned with data
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            group_access_frame_start_out <= 1'b0;
            group_access_multiframe_start_out <= 1'b0;
        end else begin
            group_access_frame_start_out <= path_frame_start_in;
            group_access_multiframe_start_out <= path_multiframe_start_in;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    logic [11:0] own_cnt_q;
    logic mf_seen_q, ais_seen_q;
    logic [7:0] cfg_prev_q;
    logic [15:0] ais_wait_q;
    // owned byte count per multiframe and signal fail response time
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            own_cnt_q <= 12'h000;
            mf_seen_q <= 1'b0;
            cfg_prev_q <= 8'h00;
            ais_seen_q <= 1'b0;
            ais_wait_q <= 16'h0000;
        end else begin
            own_cnt_q <= path_multiframe_start_in ? {11'h000, own} : own_cnt_q + 12'(own);
            // a slot change inside a multiframe spoils that count, so skip its check
            cfg_prev_q <= {small_s, l_s, m_s};
            mf_seen_q <= path_multiframe_start_in ||
                         (mf_seen_q && (cfg_prev_q == {small_s, l_s, m_s}));
            // state shown by the last driven byte; an unclaimed slot shows nothing
            if (!timeslot_claim_out) begin
                ais_seen_q <= sf_s;
            end else if (group_access_drive_out) begin
                ais_seen_q <= (group_access_data_out == `TMAP_AIS_BYTE);
            end
            ais_wait_q <= (sf_s != ais_seen_q) ? ais_wait_q + 16'h0001 : 16'h0000;
        end
    end

    sequence s_grant_slot;
        grant && own;
    endsequence

    sequence s_v1_slot;
        vslot && cur_frm == 2'h0 && !sf_s;
    endsequence

    a_drive_needs_active: assert property (@(posedge clk_in) disable iff (!rst_n)
        group_access_drive_out |-> $past(act_s) && $past(own))
        else $error("timeslot driven while not activated");
    a_claim_refused: assert property (@(posedge clk_in) disable iff (!rst_n)
        timeslot_taken_in |=> !timeslot_claim_out && !group_access_drive_out)
        else $error("taken timeslot still driven");
    a_fail_ones: assert property (@(posedge clk_in) disable iff (!rst_n)
        (s_grant_slot ##0 sf_s) |=> group_access_data_out == `TMAP_AIS_BYTE)
        else $error("all ones not sent under signal fail");
    a_fail_latency: assert property (@(posedge clk_in) disable iff (!rst_n)
        ais_wait_q < 16'(SF_RESP_CYC))
        else $error("signal fail response too slow");
    a_size_bits: assert property (@(posedge clk_in) disable iff (!rst_n)
        (s_v1_slot ##0 grant) |=> group_access_data_out[3:2] == $past(ss))
        else $error("size bits wrong in V1");
    a_pos_skip: assert property (@(posedge clk_in) disable iff (!rst_n)
        (v3p1 && just_q == TMAP_JUST_POS) |-> !rd_en ##1 rd_bin_q == $past(rd_bin_q))
        else $error("read not skipped on positive justification");
    a_neg_extra: assert property (@(posedge clk_in) disable iff (!rst_n)
        (vslot && cur_frm == 2'h2 && just_q == TMAP_JUST_NEG && !empty) |=>
        rd_bin_q == $past(rd_bin_q) + 1'b1)
        else $error("no extra read on negative justification");
    a_read_in_slot: assert property (@(posedge clk_in) disable iff (!rst_n)
        rd_en |-> own && !empty)
        else $error("buffer read outside the timeslot");
    a_tu_bytes: assert property (@(posedge clk_in) disable iff (!rst_n)
        (path_multiframe_start_in && mf_seen_q) |->
        own_cnt_q == (small_s ? `TMAP_TU12_BYTES : `TMAP_TU2_BYTES))
        else $error("timeslot byte count per multiframe wrong");
    a_gray_step: assert property (@(posedge trib_clk_in) disable iff (!trst_n)
        $countones(wr_gray_q ^ $past(wr_gray_q)) <= 1)
        else $error("write pointer moved more than one step");
endmodule

// *** bench/tmap_trib_model.sv ***
// Purpose: tributary source model feeding the mapper's elastic store
// Assumes: bytes change just after the falling edge of the tributary clock
// Notes: a released data line shows the inverse of its last value
`timescale 1ns/1ps
module tmap_trib_model (
    // tributary clock and reset
    input wire logic trib_clk_in,
    input wire logic rst_n_in,
    // control from the bench
    input wire logic enable_in,
    input wire logic small_in,
    // tributary stream
    output logic [7:0] data_out,
    output logic valid_out,
    output logic frame_start_out
);
    int cnt;
    int vc_len;

    // bytes per frame: 428 for the large, 140 for the small tributary
    assign vc_len = small_in ? 140 : 428;

    // ************************************************************
    // byte stream with frame start flag on the first byte
    // ************************************************************
    always @(negedge trib_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            data_out <= 8'h00;
            valid_out <= 1'b0;
            frame_start_out <= 1'b0;
            cnt <= 0;
        end else if (enable_in) begin
            valid_out <= 1'b1;
            data_out <= {2'h2, 6'($urandom())}; // never 00 nor FF
            frame_start_out <= (cnt == 0);
            cnt <= (cnt == vc_len - 1) ? 0 : cnt + 1;
        end else begin
            valid_out <= 1'b0;
            frame_start_out <= 1'b0;
            data_out <= ~data_out; // released line, no stale value
        end
    end
endmodule

// *** bench/tug2_tributary_mapper_source_test.sv ***
// Purpose: self-checking bench of the tributary mapper source
// Assumes: path timing made here, one byte position per clk_in cycle
// Notes: partner model supplies the tributary stream on its own clock
`timescale 1ns/1ps
`include "tmap_consts.svh"
module tug2_tributary_mapper_source_test;
    logic clk_in, trib_clk, rst_n, fs, mfs, taken, act, sf, tu_small, pen, run;
    logic [4:0] l_sel;
    logic [1:0] m_sel;
    logic [7:0] t_data, data;
    logic t_valid, t_fs, drive, fs_out, mfs_out, claim, prev_fs, prev_mfs;
    logic [7:0] v1b, v3b, v3p1b, nxtb;
    int fail_count, samples_checked, gcyc, cycles, pos, frm, col, row, first, step, dcount;
    int sf_mode;
    bit chk_on, exp_drive, own;

    // ************************************************************
    // clocks, unrelated in phase
    // ************************************************************
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    initial begin
        trib_clk = 1'b0;
        #17;
        forever #62.5 trib_clk = ~trib_clk;
    end

    // response bound above the widest gap between owned bytes of a small slot
    tmap_tug2_mapper #(.SF_RESP_CYC(100)) dut_u (
        .clk_in(clk_in), .rst_n_in(rst_n), .trib_clk_in(trib_clk),
        .vc_large_tributary_data_in(t_data), .vc_small_tributary_data_in(t_data),
        .trib_byte_valid_in(t_valid), .trib_frame_start_in(t_fs),
        .path_frame_start_in(fs), .path_multiframe_start_in(mfs),
        .timeslot_taken_in(taken), .function_activate_in(act),
        .upstream_signal_fail_in(sf), .tu_is_small_in(tu_small),
        .group_l_in(l_sel), .member_m_in(m_sel),
        .group_access_data_out(data), .group_access_drive_out(drive),
        .group_access_frame_start_out(fs_out),
        .group_access_multiframe_start_out(mfs_out), .timeslot_claim_out(claim));

    tmap_trib_model trib_u (
        .trib_clk_in(trib_clk), .rst_n_in(rst_n), .enable_in(pen), .small_in(tu_small),
        .data_out(t_data), .valid_out(t_valid), .frame_start_out(t_fs));

    // ************************************************************
    // comparison, verdict and hang guard
    // ************************************************************
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
            fail_count++;
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 90000) begin
            fail_count++;
            test_done();
        end
    end

    // path frame timing: 2160 cycles a frame, four frames a multiframe
    always @(negedge clk_in) begin
        if (run) begin
            fs <= (gcyc % 2160 == 0);
            mfs <= (gcyc == 0);
            gcyc <= (gcyc == 8639) ? 0 : gcyc + 1;
        end
    end

    // ************************************************************
    // monitor: outputs at an edge belong to the position taken one edge before
    // ************************************************************
    always @(posedge clk_in) begin
        if (run) begin
            col = pos % 240;
            row = pos / 240;
            own = (col % 20 == l_sel - 1) && (!tu_small || (col / 20) % 3 == m_sel - 1);
            first = tu_small ? (m_sel - 1) * 20 + l_sel - 1 : l_sel - 1;
            step = tu_small ? 60 : 20;
            check("frame_start_out", fs_out, prev_fs);
            check("mframe_start_out", mfs_out, prev_mfs);
            if (chk_on) begin
                check("drive", drive, own && exp_drive);
                if (drive) dcount++;
                if (sf_mode == 1 && drive) check("ones", data, 8'hFF);
                if (sf_mode == 2 && drive && row != 0) check("resume", data[7:6], 2'h2);
            end
            if (row == 0 && frm == 0 && col == first) v1b = data;
            if (row == 0 && frm == 2 && col == first) v3b = data;
            if (row == 0 && frm == 2 && col == first + step) v3p1b = data;
            if (row == 0 && frm == 2 && col == first + 2 * step) nxtb = data;
            prev_fs = fs;
            prev_mfs = mfs;
            if (fs) begin
                pos = 0;
                frm = mfs ? 0 : frm + 1;
            end else begin
                pos++;
            end
        end
    end

    // ************************************************************
    // sequence helpers
    // ************************************************************
    task automatic wait_mf();
        do @(posedge clk_in); while (mfs !== 1'b1);
        #1;
    endtask

    task automatic cfg(input logic sm, input logic [4:0] l, input logic [1:0] m);
        chk_on = 0;
        @(negedge clk_in);
        tu_small = sm;
        l_sel = l;
        m_sel = m;
        wait_mf();
    endtask

    // counts owned bytes over one multiframe and checks the pointer byte
    task automatic measure(input logic [15:0] cnt, input logic [1:0] ss);
        dcount = 0;
        chk_on = 1;
        wait_mf();
        check("owned_bytes", 16'(dcount), cnt);
        check("size_bits", v1b[3:2], ss);
        check("ndf_bits", v1b[7:4], `TMAP_NDF_NORMAL);
    endtask

    task automatic idle_frame(input bit ex);
        chk_on = 0;
        repeat (10) @(negedge clk_in);
        exp_drive = ex;
        chk_on = 1;
        repeat (2160) @(negedge clk_in);
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        {rst_n, fs, mfs, taken, sf, tu_small, pen, run, prev_fs, prev_mfs} = '0;
        act = 1'b1;
        l_sel = 5'h01;
        m_sel = 2'h1;
        exp_drive = 1;
        void'($urandom(48083));
        repeat (20) @(negedge clk_in);
        rst_n = 1'b1;
        repeat (4) @(negedge clk_in);
        run = 1'b1;
        // starved store forces a positive step, then a flood a negative one
        cfg(1'b0, 5'h01, 2'h1);
        wait_mf();
        pen = 1'b1;
        measure(16'(`TMAP_TU2_BYTES), `TMAP_SS_TU2);
        check("v3p1_empty", v3p1b, 8'h00);
        check("after_v3p1", nxtb[7:6], 2'h2);
        wait_mf();
        check("v3_extra", v3b[7:6], 2'h2);
        // last group index, then signal fail and recovery
        cfg(1'b0, 5'h14, 2'h1);
        measure(16'(`TMAP_TU2_BYTES), `TMAP_SS_TU2);
        @(negedge clk_in);
        sf = 1'b1;
        repeat (60) @(negedge clk_in);
        sf_mode = 1;
        repeat (2160) @(negedge clk_in);
        sf_mode = 0;
        sf = 1'b0;
        repeat (60) @(negedge clk_in);
        sf_mode = 2;
        repeat (2160) @(negedge clk_in);
        sf_mode = 0;
        // small tributary at a random group and member
        cfg(1'b1, 5'($urandom_range(20, 1)), 2'($urandom_range(3, 1)));
        measure(16'(`TMAP_TU12_BYTES), `TMAP_SS_TU12);
        // deactivated, then slot owned elsewhere, then claimed again
        @(negedge clk_in);
        act = 1'b0;
        idle_frame(0);
        check("claim_inactive", claim, 1'b0);
        chk_on = 0;
        act = 1'b1;
        taken = 1'b1;
        idle_frame(0);
        check("claim_taken", claim, 1'b0);
        chk_on = 0;
        taken = 1'b0;
        idle_frame(1);
        check("claim_free", claim, 1'b1);
        test_done();
    end
endmodule
